// ### hw/adc_ctrl_params.svh
// Register offsets, field positions, reset values and timing figures of the converter control
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// Register offsets on the byte-wide register port
`define REG_MODE        4'h0
`define REG_SOFT_TRIG   4'h1
`define REG_IRQ_STATUS  4'h2
`define REG_IRQ_MASK    4'h3
`define REG_RESULT_LO   4'h4
`define REG_RESULT_HI   4'h5
`define REG_CONTROL     4'h6
`define REG_TARGET_LO   4'h7
`define REG_TARGET_HI   4'h8
`define REG_COUNT_LO    4'h9
`define REG_COUNT_HI    4'hA
`define REG_DIV1_LO     4'hB
`define REG_DIV1_HI     4'hC
`define REG_DIV2_LO     4'hD
`define REG_DIV2_HI     4'hE

// Field positions
`define CTRL_START_BIT  0
`define CTRL_STOP_BIT   1
`define CTRL_CHAN_BIT   2
`define STAT_DRDY_BIT   0
`define STAT_RUN_BIT    1
`define STAT_DONE_BIT   2
`define IRQ_CONV_BIT    0
`define IRQ_TC_BIT      1
`define IRQ_END_BIT     2

// Reset values
`define MODE_RESET      3'h1
`define IRQ_MASK_RESET  3'h0
`define DIV_RESET       16'h0000

// Timing: pacer base derived from the system clock by a fractional accumulator
`define CLK_HZ          25000000
`define PACER_BASE_HZ   2000000
`define RATE_UNIT_HZ    1000000
`define PACER_ACC_STEP  (`PACER_BASE_HZ / `RATE_UNIT_HZ)
`define PACER_ACC_MOD   (`CLK_HZ / `RATE_UNIT_HZ)

`endif

// ### hw/adc_ctrl_pkg.sv
// Types shared by the converter control modules
package adc_ctrl_pkg;

  typedef enum logic [2:0] {
    MODE_EXT_POLL   = 3'h0,
    MODE_SOFT_POLL  = 3'h1,
    MODE_PACER_DMA  = 3'h2,
    MODE_EXT_DMA    = 3'h3,
    MODE_EXT_INT    = 3'h4,
    MODE_SOFT_INT   = 3'h5,
    MODE_PACER_INT  = 3'h6,
    MODE_UNUSED     = 3'h7
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } run_state_t;

endpackage : adc_ctrl_pkg

// ### hw/pacer_if.sv
// Signals between the control logic and its pacer timer pair
`timescale 1ns/1ps
interface pacer_if;
  logic [15:0] div_first;
  logic [15:0] div_second;
  logic        run;
  logic        tick;

  modport ctl (output div_first, output div_second, output run, input tick);
  modport tmr (input div_first, input div_second, input run, output tick);
endinterface : pacer_if

// ### hw/pacer_timer.sv
// Cascaded pair of 16-bit pacer dividers on a 2 MHz base
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
module pacer_timer
  import adc_ctrl_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  pacer_if.tmr      pif
);

  localparam logic [4:0] ACC_STEP = 5'(`PACER_ACC_STEP);
  localparam logic [4:0] ACC_MOD  = 5'(`PACER_ACC_MOD);

  logic [4:0]  acc_ff;
  logic [15:0] cnt1_ff;
  logic [15:0] cnt2_ff;
  logic        tick_ff;

  // Averages exactly 2 MHz; jitter is one system clock, fine for a pacer
  wire  [4:0]  acc_sum   = acc_ff + ACC_STEP;
  wire         base_tick = (acc_sum >= ACC_MOD);
  wire  [4:0]  nxt_acc   = base_tick ? 5'(acc_sum - ACC_MOD) : acc_sum;
  wire         div_ok    = (pif.div_first != 16'h0000) && (pif.div_second != 16'h0000);
  wire         wrap1     = base_tick && (cnt1_ff <= 16'h0001);
  wire         wrap2     = wrap1 && (cnt2_ff <= 16'h0001);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_ff  <= 5'h00;
      cnt1_ff <= 16'h0000;
      cnt2_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (!pif.run || !div_ok) begin
      acc_ff  <= 5'h00;
      cnt1_ff <= pif.div_first;
      cnt2_ff <= pif.div_second;
      tick_ff <= 1'b0;
    end else begin
      acc_ff  <= nxt_acc;
      if (base_tick) begin
        cnt1_ff <= wrap1 ? pif.div_first : 16'(cnt1_ff - 16'h0001);
      end
      if (wrap1) begin
        cnt2_ff <= wrap2 ? pif.div_second : 16'(cnt2_ff - 16'h0001);
      end
      tick_ff <= wrap2;
    end
  end

  assign pif.tick = tick_ff;

endmodule : pacer_timer

// ### hw/adc_trigger_transfer_control.sv
// Converter trigger selection, result transfer, counted runs and interrupt logic
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
module adc_trigger_transfer_control
  import adc_ctrl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic      [7:0]  rd_data_out,
  input  wire logic        ext_trig_in,
  output logic             conv_start_out,
  input  wire logic [11:0] adc_data_in,
  input  wire logic        adc_done_in,
  output logic             host_dma_chan_one_out,
  output logic             host_dma_chan_three_out,
  input  wire logic        dma_ack_in,
  input  wire logic        dma_tc_in,
  output logic      [11:0] dma_data_out,
  output logic             irq_out,
  output logic             data_ready_n_out
);

  pacer_if pif ();

  // Registers
  mode_t       mode_ff;
  run_state_t  state_ff;
  logic [2:0]  irq_stat_ff;
  logic [2:0]  irq_mask_ff;
  logic [15:0] pacer_div_first_ff;
  logic [15:0] pacer_div_second_ff;
  logic [15:0] target_ff;
  logic [15:0] count_ff;
  logic [11:0] result_ff;
  logic [11:0] dma_data_ff;
  logic        chan_three_ff;
  logic        busy_ff;
  logic        dma_pend_ff;
  logic        drdy_n_ff;
  logic        conv_start_ff;
  logic        irq_ff;
  logic [7:0]  rd_data_ff;
  logic [2:0]  ext_sync_ff;

  // Register port decode
  wire wr_mode    = wr_en_in && (addr_in == `REG_MODE);
  wire wr_soft    = wr_en_in && (addr_in == `REG_SOFT_TRIG);
  wire wr_clr     = wr_en_in && (addr_in == `REG_IRQ_STATUS);
  wire wr_mask    = wr_en_in && (addr_in == `REG_IRQ_MASK);
  wire wr_ctrl    = wr_en_in && (addr_in == `REG_CONTROL);
  wire wr_tgt_lo  = wr_en_in && (addr_in == `REG_TARGET_LO);
  wire wr_tgt_hi  = wr_en_in && (addr_in == `REG_TARGET_HI);
  wire wr_d1_lo   = wr_en_in && (addr_in == `REG_DIV1_LO);
  wire wr_d1_hi   = wr_en_in && (addr_in == `REG_DIV1_HI);
  wire wr_d2_lo   = wr_en_in && (addr_in == `REG_DIV2_LO);
  wire wr_d2_hi   = wr_en_in && (addr_in == `REG_DIV2_HI);
  wire rd_res_hi  = rd_en_in && (addr_in == `REG_RESULT_HI);

  wire start_cmd  = wr_ctrl && wr_data_in[`CTRL_START_BIT];
  wire stop_cmd   = wr_ctrl && wr_data_in[`CTRL_STOP_BIT];
  wire running    = (state_ff == ST_RUN);

  // Mode decode
  wire trig_ext   = (mode_ff == MODE_EXT_POLL) || (mode_ff == MODE_EXT_DMA) ||
                    (mode_ff == MODE_EXT_INT);
  wire trig_soft  = (mode_ff == MODE_SOFT_POLL) || (mode_ff == MODE_SOFT_INT);
  wire trig_pacer = (mode_ff == MODE_PACER_DMA) || (mode_ff == MODE_PACER_INT);
  wire xfer_dma   = (mode_ff == MODE_PACER_DMA) || (mode_ff == MODE_EXT_DMA);
  wire xfer_int   = (mode_ff == MODE_EXT_INT) || (mode_ff == MODE_SOFT_INT) ||
                    (mode_ff == MODE_PACER_INT);

  // Trigger sources; only the second and third sync stages feed the edge detector
  wire ext_rise   = ext_sync_ff[1] && !ext_sync_ff[2];
  wire soft_go    = wr_soft && trig_soft;
  wire ext_go     = ext_rise && trig_ext;
  wire pacer_go   = pif.tick && trig_pacer && running;
  wire conv_go    = (soft_go || ext_go || pacer_go) && !busy_ff;
  wire conv_done  = adc_done_in && busy_ff;

  // Transfer accounting
  wire dma_take   = dma_pend_ff && dma_ack_in;
  wire tc_hit     = dma_take && dma_tc_in;
  wire int_take   = conv_done && xfer_int && running;
  wire count_inc  = running && (dma_take || int_take);
  wire [15:0] nxt_count = count_inc ? 16'(count_ff + 16'h0001) : count_ff;
  wire reach_n    = count_inc && (target_ff != 16'h0000) && (nxt_count == target_ff);
  wire run_end    = running && (reach_n || tc_hit || stop_cmd);

  // Interrupt events; hardware set wins over a same-cycle clear
  wire [2:0] irq_set;
  assign irq_set[`IRQ_CONV_BIT] = conv_done && xfer_int;
  assign irq_set[`IRQ_TC_BIT]   = tc_hit;
  assign irq_set[`IRQ_END_BIT]  = running && (reach_n || tc_hit);
  wire [2:0] irq_clr      = wr_clr ? wr_data_in[2:0] : 3'h0;
  wire [2:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;
  wire       nxt_irq      = |(nxt_irq_stat & irq_mask_ff);

  // Run state
  run_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: if (start_cmd) nxt_state = ST_RUN;
      ST_RUN:  if (run_end) nxt_state = ST_DONE;
      ST_DONE: if (start_cmd) nxt_state = ST_RUN;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Read selection; upper result nibble reads as zero
  wire [7:0] stat_byte = {5'h00, (state_ff == ST_DONE), running, drdy_n_ff};
  wire [7:0] rd_mux =
    (addr_in == `REG_MODE)       ? {5'h00, mode_ff} :
    (addr_in == `REG_SOFT_TRIG)  ? stat_byte :
    (addr_in == `REG_IRQ_STATUS) ? {5'h00, irq_stat_ff} :
    (addr_in == `REG_IRQ_MASK)   ? {5'h00, irq_mask_ff} :
    (addr_in == `REG_RESULT_LO)  ? result_ff[7:0] :
    (addr_in == `REG_RESULT_HI)  ? {4'h0, result_ff[11:8]} :
    (addr_in == `REG_CONTROL)    ? {5'h00, chan_three_ff, 1'b0, running} :
    (addr_in == `REG_TARGET_LO)  ? target_ff[7:0] :
    (addr_in == `REG_TARGET_HI)  ? target_ff[15:8] :
    (addr_in == `REG_COUNT_LO)   ? count_ff[7:0] :
    (addr_in == `REG_COUNT_HI)   ? count_ff[15:8] :
    (addr_in == `REG_DIV1_LO)    ? pacer_div_first_ff[7:0] :
    (addr_in == `REG_DIV1_HI)    ? pacer_div_first_ff[15:8] :
    (addr_in == `REG_DIV2_LO)    ? pacer_div_second_ff[7:0] :
    (addr_in == `REG_DIV2_HI)    ? pacer_div_second_ff[15:8] : 8'h00;

  // Host registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_ff             <= mode_t'(`MODE_RESET);
      irq_mask_ff         <= `IRQ_MASK_RESET;
      chan_three_ff       <= 1'b0;
      target_ff           <= 16'h0000;
      pacer_div_first_ff  <= `DIV_RESET;
      pacer_div_second_ff <= `DIV_RESET;
    end else begin
      if (wr_mode)   mode_ff <= mode_t'(wr_data_in[2:0]);
      if (wr_mask)   irq_mask_ff <= wr_data_in[2:0];
      if (wr_ctrl)   chan_three_ff <= wr_data_in[`CTRL_CHAN_BIT];
      if (wr_tgt_lo) target_ff[7:0] <= wr_data_in;
      if (wr_tgt_hi) target_ff[15:8] <= wr_data_in;
      if (wr_d1_lo)  pacer_div_first_ff[7:0] <= wr_data_in;
      if (wr_d1_hi)  pacer_div_first_ff[15:8] <= wr_data_in;
      if (wr_d2_lo)  pacer_div_second_ff[7:0] <= wr_data_in;
      if (wr_d2_hi)  pacer_div_second_ff[15:8] <= wr_data_in;
    end
  end

  // Run control and counting
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= ST_IDLE;
      count_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      // Count survives a stop so software can read how far it got
      count_ff <= start_cmd && !running ? 16'h0000 : nxt_count;
    end
  end

  // Conversion sequencing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_sync_ff   <= 3'h0;
      conv_start_ff <= 1'b0;
      busy_ff       <= 1'b0;
      result_ff     <= 12'h000;
      drdy_n_ff     <= 1'b1;
    end else begin
      ext_sync_ff   <= {ext_sync_ff[1:0], ext_trig_in};
      conv_start_ff <= conv_go;
      if (conv_go) begin
        busy_ff   <= 1'b1;
        drdy_n_ff <= 1'b1;
      end else if (conv_done) begin
        busy_ff   <= 1'b0;
        result_ff <= adc_data_in;
        drdy_n_ff <= 1'b0;
      end else if (rd_res_hi) begin
        drdy_n_ff <= 1'b1;
      end
    end
  end

  // DMA handshake and interrupt
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dma_pend_ff <= 1'b0;
      dma_data_ff <= 12'h000;
      irq_stat_ff <= 3'h0;
      irq_ff      <= 1'b0;
      rd_data_ff  <= 8'h00;
    end else begin
      // A new result overwrites an unacknowledged one; the pacer limit prevents it
      if (conv_done && xfer_dma) begin
        dma_pend_ff <= 1'b1;
        dma_data_ff <= adc_data_in;
      end else if (dma_take) begin
        dma_pend_ff <= 1'b0;
      end
      irq_stat_ff <= nxt_irq_stat;
      irq_ff      <= nxt_irq;
      rd_data_ff  <= rd_en_in ? rd_mux : 8'h00;
    end
  end

  assign pif.div_first  = pacer_div_first_ff;
  assign pif.div_second = pacer_div_second_ff;
  assign pif.run        = running && trig_pacer;

  pacer_timer u_pacer (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .pif    (pif)
  );

  // Request lines come from flops gated only by the channel select flop
  logic dma_one_ff;
  logic dma_three_ff;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dma_one_ff   <= 1'b0;
      dma_three_ff <= 1'b0;
    end else begin
      dma_one_ff   <= (conv_done && xfer_dma || dma_pend_ff && !dma_ack_in) && !chan_three_ff;
      dma_three_ff <= (conv_done && xfer_dma || dma_pend_ff && !dma_ack_in) && chan_three_ff;
    end
  end

  assign host_dma_chan_one_out   = dma_one_ff;
  assign host_dma_chan_three_out = dma_three_ff;
  assign dma_data_out            = dma_data_ff;
  assign rd_data_out             = rd_data_ff;
  assign conv_start_out          = conv_start_ff;
  assign irq_out                 = irq_ff;
  assign data_ready_n_out        = drdy_n_ff;

endmodule : adc_trigger_transfer_control

// ### verification/far_side_model.sv
// Converter and host DMA controller model facing the control block
`timescale 1ns/1ps
module far_side_model #(
  parameter int CONV_CYC = 8,
  parameter int ACK_CYC  = 3
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        start_in,
  input  wire logic        dma_req_in,
  input  wire logic [11:0] value_in,
  input  wire logic [3:0]  tc_at_in,
  output logic      [11:0] data_out,
  output logic             done_out,
  output logic             ack_out,
  output logic             tc_out
);
  int         conv_ff;
  int         wait_ff;
  logic [3:0] acks_ff;
  logic       ack_go;
  // Released result bus shows the inverse, so stale data never matches
  assign data_out = done_out ? value_in : ~value_in;
  assign ack_go   = dma_req_in && !ack_out && wait_ff == ACK_CYC - 1;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_ff <= 0;
      wait_ff <= 0;
      acks_ff <= 4'h0;
      done_out <= 1'b0;
      ack_out <= 1'b0;
      tc_out <= 1'b0;
    end else begin
      done_out <= conv_ff == 1;
      if (start_in && conv_ff == 0) conv_ff <= CONV_CYC;
      else if (conv_ff != 0) conv_ff <= conv_ff - 1;
      ack_out <= ack_go;
      tc_out <= ack_go && tc_at_in == acks_ff + 4'h1;
      wait_ff <= (dma_req_in && !ack_out && !ack_go) ? wait_ff + 1 : 0;
      if (tc_at_in == 4'h0) acks_ff <= 4'h0;
      else if (ack_out) acks_ff <= acks_ff + 4'h1;
    end
  end
endmodule : far_side_model

// ### verification/adc_ctrl_properties.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
module adc_ctrl_properties (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic [3:0] addr_in,
  input wire logic       wr_en_in,
  input wire logic       rd_en_in,
  input wire logic [7:0] rd_data_out,
  input wire logic       conv_start_out,
  input wire logic       adc_done_in,
  input wire logic       host_dma_chan_one_out,
  input wire logic       host_dma_chan_three_out,
  input wire logic       dma_ack_in,
  input wire logic       irq_out,
  input wire logic       data_ready_n_out
);
  logic       busy_ff;
  logic [2:0] clr_hist_ff;
  logic       dma_req;
  logic       irq_wr;
  assign dma_req = host_dma_chan_one_out | host_dma_chan_three_out;
  assign irq_wr  = wr_en_in && (addr_in == `REG_IRQ_STATUS || addr_in == `REG_IRQ_MASK);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_ff <= 1'b0;
      clr_hist_ff <= 3'h0;
    end else begin
      busy_ff <= conv_start_out | (busy_ff & ~adc_done_in);
      clr_hist_ff <= {clr_hist_ff[1:0], irq_wr};
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_read_slot: assert property (rd_data_out != 8'h00 |-> $past(rd_en_in))
    else $error("read data outside its slot");
  a_no_retrigger: assert property (conv_start_out |-> !busy_ff)
    else $error("conversion restarted while busy");
  a_ready_done: assert property (adc_done_in && busy_ff |=> !data_ready_n_out)
    else $error("data ready missing after result");
  a_ready_read: assert property (rd_en_in && addr_in == `REG_RESULT_HI && !adc_done_in
    |=> data_ready_n_out)
    else $error("data ready not released by read");
  a_high_nibble: assert property (rd_en_in && addr_in == `REG_RESULT_HI
    |=> rd_data_out[7:4] == 4'h0)
    else $error("result wider than twelve bits");
  a_one_dma_line: assert property (!(host_dma_chan_one_out && host_dma_chan_three_out))
    else $error("both DMA lines requested");
  a_req_release: assert property (dma_req && dma_ack_in && !adc_done_in |=> !dma_req)
    else $error("DMA request held after ack");
  a_irq_hold: assert property ($fell(irq_out) |-> |clr_hist_ff)
    else $error("interrupt dropped without clear");
  c_start: cover property (conv_start_out);
  c_dma_ack: cover property (dma_req && dma_ack_in);
  c_irq_clear: cover property ($fell(irq_out));
endmodule : adc_ctrl_properties
bind adc_trigger_transfer_control adc_ctrl_properties i_props (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_en_in(wr_en_in),
  .rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .conv_start_out(conv_start_out),
  .adc_done_in(adc_done_in), .host_dma_chan_one_out(host_dma_chan_one_out),
  .host_dma_chan_three_out(host_dma_chan_three_out), .dma_ack_in(dma_ack_in),
  .irq_out(irq_out), .data_ready_n_out(data_ready_n_out));

// ### verification/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
module tb_top;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        ext_trig = 1'b0;
  logic [11:0] val = 12'h000;
  logic [3:0]  tc_at = 4'h0;
  logic [7:0]  rd_data;
  logic [11:0] adc_data, dma_data;
  logic        conv_start, adc_done, ch_one, ch_three, ack, tc, irq, rdy_n;
  int error_cnt = 0;
  int total_checks = 0;
  int starts = 0, mark = 0, cyc = 0, last_st = 0, gap = 0, acks_one = 0, acks_three = 0;
  always #20 clk_in = ~clk_in;
  adc_trigger_transfer_control i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .rd_data_out(rd_data), .ext_trig_in(ext_trig), .conv_start_out(conv_start),
    .adc_data_in(adc_data), .adc_done_in(adc_done), .host_dma_chan_one_out(ch_one),
    .host_dma_chan_three_out(ch_three), .dma_ack_in(ack), .dma_tc_in(tc),
    .dma_data_out(dma_data), .irq_out(irq), .data_ready_n_out(rdy_n));
  far_side_model i_far (
    .clk_in(clk_in), .rst_in(rst_in), .start_in(conv_start), .dma_req_in(ch_one | ch_three),
    .value_in(val), .tc_at_in(tc_at), .data_out(adc_data), .done_out(adc_done),
    .ack_out(ack), .tc_out(tc));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (conv_start) begin
      starts <= starts + 1;
      gap <= cyc - last_st;
      last_st <= cyc;
    end
    if (ack) begin
      acks_one <= acks_one + int'(ch_one);
      acks_three <= acks_three + int'(ch_three);
      chk("dma data", {4'h0, val}, {4'h0, dma_data});
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : idle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_in);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d});
  endtask : rdc
  // Bounded wait: 0 data ready, 1 interrupt, 2 a new start
  task automatic wait_for(input int w, input int lim);
    int n;
    n = 0;
    while (n <= lim && !(w == 0 ? rdy_n === 1'b0 : w == 1 ? irq === 1'b1 : starts > mark)) begin
      @(posedge clk_in);
      n++;
    end
    // A used-up bound is a mismatch and ends the run here
    if (n > lim) begin
      chk("wait bound", 16'h0000, 16'h0001);
      finish_test();
    end
  endtask : wait_for
  initial begin
    logic [7:0] d;
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    rdc(`REG_MODE, 8'h01, "mode reset");
    rdc(`REG_SOFT_TRIG, 8'h01, "idle status");
    rdc(4'hF, 8'h00, "unmapped");
    for (int k = 0; k < 2; k++) begin
      val = k ? 12'h000 : 12'hFFF;
      wr(`REG_SOFT_TRIG, 8'h00);
      wait_for(0, 100);
      rdc(`REG_RESULT_LO, val[7:0], "result low");
      rdc(`REG_RESULT_HI, {4'h0, val[11:8]}, "result high");
      chk("ready after read", 16'h0001, {15'h0, rdy_n});
    end
    for (int m = 0; m < 8; m++) begin
      wr(`REG_MODE, 8'(m));
      rdc(`REG_MODE, 8'(m), "mode code");
      mark = starts;
      wr(`REG_SOFT_TRIG, 8'h00);
      idle(20);
      ext_trig <= 1'b1;
      idle(4);
      ext_trig <= 1'b0;
      idle(20);
      chk("starts in mode", 16'(int'(m == 1 || m == 5) + int'(m == 0 || m == 3 || m == 4)),
          16'(starts - mark));
    end
    wr(`REG_MODE, 8'h01);
    mark = starts;
    @(posedge clk_in);
    addr <= `REG_SOFT_TRIG;
    wr_en <= 1'b1;
    repeat (3) @(posedge clk_in);
    wr_en <= 1'b0;
    idle(20);
    chk("retrigger", 16'h0001, 16'(starts - mark));
    wr(`REG_IRQ_STATUS, 8'hFF);
    wr(`REG_MODE, 8'h05);
    wr(`REG_SOFT_TRIG, 8'h00);
    idle(20);
    chk("masked irq", 16'h0000, {15'h0, irq});
    rdc(`REG_IRQ_STATUS, 8'h01, "conv status");
    wr(`REG_IRQ_MASK, 8'h01);
    wr(`REG_SOFT_TRIG, 8'h00);
    idle(20);
    chk("irq held", 16'h0001, {15'h0, irq});
    wr(`REG_IRQ_STATUS, 8'h01);
    idle(3);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    // Product 22 keeps the pacer under the converter limit
    wr(`REG_DIV1_LO, 8'h02);
    wr(`REG_DIV2_LO, 8'h0B);
    wr(`REG_MODE, 8'h06);
    wr(`REG_IRQ_MASK, 8'h04);
    wr(`REG_TARGET_LO, 8'h03);
    mark = starts;
    wr(`REG_CONTROL, 8'h01);
    wait_for(1, 1500);
    chk("pacer conversions", 16'h0003, 16'(starts - mark));
    chk("pacer gap", 16'h0001, 16'(gap >= 262 && gap <= 288));
    rdc(`REG_COUNT_LO, 8'h03, "run count");
    rdc(`REG_IRQ_STATUS, 8'h05, "run end status");
    rd(`REG_SOFT_TRIG, d);
    chk("run done", 16'h0004, {8'h00, d & 8'h06});
    wr(`REG_IRQ_STATUS, 8'hFF);
    wr(`REG_TARGET_LO, 8'h00);
    rd(`REG_RESULT_HI, d);
    wr(`REG_CONTROL, 8'h01);
    rd(`REG_SOFT_TRIG, d);
    chk("running", 16'h0002, {8'h00, d & 8'h06});
    wait_for(0, 400);
    wr(`REG_CONTROL, 8'h02);
    mark = starts;
    idle(700);
    chk("stopped pacer", 16'h0000, 16'(starts - mark));
    rdc(`REG_COUNT_LO, 8'h01, "kept count");
    rdc(`REG_COUNT_HI, 8'h00, "kept count high");
    wr(`REG_DIV2_LO, 8'h00);
    wr(`REG_CONTROL, 8'h01);
    idle(700);
    chk("zero divider", 16'h0000, 16'(starts - mark));
    wr(`REG_CONTROL, 8'h02);
    wr(`REG_DIV2_LO, 8'h0B);
    wr(`REG_MODE, 8'h02);
    // Counted DMA runs: channel three ending on terminal count, then channel one ending on the target count
    for (int k = 0; k < 2; k++) begin
      val = k ? 12'h5A3 : 12'hA5C;
      tc_at <= k ? 4'h0 : 4'h2;
      // Ack counters belong to the monitor; keep a baseline instead of clearing
      mark = k ? acks_one : acks_three;
      wr(`REG_IRQ_STATUS, 8'hFF);
      wr(`REG_TARGET_LO, k ? 8'h02 : 8'h00);
      wr(`REG_CONTROL, k ? 8'h01 : 8'h05);
      wait_for(1, 1500);
      idle(2);
      rdc(`REG_COUNT_LO, 8'h02, "dma count");
      rdc(`REG_IRQ_STATUS, k ? 8'h04 : 8'h06, "dma status");
      rdc(`REG_CONTROL, k ? 8'h00 : 8'h04, "chan select");
      chk("acks on line", 16'h0002, 16'((k ? acks_one : acks_three) - mark));
    end
    finish_test();
  end
endmodule : tb_top
